// ### hp_defines.svh
// constants for the high-precision value bank
`ifndef HP_DEFINES_SVH
`define HP_DEFINES_SVH

// parameter code numbers
`define HP_CODE_W       11
`define HP_CODE_MAIN    11'h17c
`define HP_CODE_LOOP    11'h17d
`define HP_CODE_MEAS    11'h17e
`define HP_CODE_TLIM    11'h183
`define HP_CODE_TDEM    11'h184
`define HP_CODE_PHASE   11'h187
`define HP_CODE_FIELD   11'h188
`define HP_CODE_EXTRA   11'h189

// value spans, 14 bits plus sign; loop sum span 15 bits plus sign
`define HP_FULL_POS     16'h4000
`define HP_FULL_NEG     16'hc000
`define HP_SUM_POS      17'h07fff
`define HP_SUM_NEG      17'h18001

// reset values
`define HP_MAIN_RESET   16'h0000
`define HP_TLIM_RESET   16'h4000
`define HP_FIELD_RESET  16'h4000

`endif

// ### hp_pkg.sv
// types of the high-precision value bank
package hp_pkg;
`include "hp_defines.svh"

   // one parameter access, from the communication side or the keypad (from_comm)
   typedef struct packed {
      logic                   valid;
      logic                   write;
      logic                   from_comm;
      logic [`HP_CODE_W-1:0]  code;
      logic [15:0]            wdata;
   } hp_req_type;

   // answer to one parameter access
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [15:0] rdata;
   } hp_rsp_type;

endpackage : hp_pkg

// ### hp_value_bank.sv
// high-precision set and actual value bank of a dc speed controller
`timescale 1ns/1ns
`include "hp_defines.svh"

// Notes on behaviour
// RULE1 - each value has 14 bits of magnitude plus a sign
// RULE2 - words reachable only from the communication interface, not keypad
// RULE3 - controller values pass straight through, no scaling, no rounding
// RULE4 - main speed setpoint: 16384 equals configured maximum speed
// RULE5 - main setpoint read/write, -16384..16384; host writes only that span
// RULE6 - loop input is read-only sum of ramped main and extra, +-32767
// RULE7 - measured speed read-only, 16384 equals configured maximum speed
// RULE8 - torque limit read/write, 16384 is full torque, -16384..16384
// RULE9 - torque demand read-only display, 16384 is full torque
// RULE10 - rotor phase from encoder, 16384 counts per revolution
// RULE11 - rotor phase unsigned up to 65535, four turns before wrap
// RULE12 - incremental encoder: phase reads zero until zero mark seen
// RULE13 - field current setpoint never below configured minimum field
// RULE14 - in field weakening a larger field setpoint does not leave it
// RULE15 - field current setpoint spans 0..16384, 16384 is rated field
// RULE16 - field setpoint loadable from a cyclic process input word
// RULE17 - extra setpoint word reports supplementary demand, 16384 full
// RULE18 - signed words 16-bit two's complement, phase and field unsigned
module hp_value_bank
   import hp_pkg::*;
(
   // clock and reset
   input  wire logic               i_clk_sys,
   input  wire logic               i_reset,
   // parameter access
   input  wire hp_req_type         i_req,
   output hp_rsp_type              o_rsp,
   // controller values, already normalised
   input  wire logic signed [15:0] i_main_ramped,
   input  wire logic signed [15:0] i_extra_ramped,
   input  wire logic signed [15:0] i_speed_meas,
   input  wire logic signed [15:0] i_torque_demand,
   input  wire logic signed [15:0] i_extra_setpoint,
   // encoder and field status
   input  wire logic [15:0]        i_phase_count,
   input  wire logic               i_enc_incremental,
   input  wire logic               i_zero_mark,
   input  wire logic               i_field_weak,
   input  wire logic [15:0]        i_min_field,
   // cyclic process input word
   input  wire logic               i_pd_valid,
   input  wire logic               i_pd_map_field,
   input  wire logic [15:0]        i_pd_word,
   // setpoints to the controller
   output logic signed [15:0]      o_main_setpoint,
   output logic signed [15:0]      o_torque_limit,
   output logic [15:0]             o_field_setpoint
);

   // stored words
   logic signed [15:0] main_reg;
   logic signed [15:0] tlim_reg;
   logic [15:0]        field_reg;
   hp_rsp_type         rsp_reg;
   // zero mark synchroniser and sticky flag
   logic               zm_meta_reg;
   logic               zm_sync_reg;
   logic               zero_seen_reg;

   // combinational helpers
   logic signed [15:0] wsig;
   logic               sig_in_span;
   logic               acc_ok;
   logic               wr_ok;
   logic               wr_main;
   logic               wr_tlim;
   logic               wr_field;
   logic               pd_field;
   logic [15:0]        fld_src;
   logic [15:0]        min_eff;
   logic [15:0]        fld_floor;
   logic [15:0]        fld_next;
   logic [15:0]        keep_floor;
   logic signed [16:0] loop_sum;
   logic signed [15:0] loop_sat;
   logic [15:0]        phase_view;
   hp_rsp_type         rsp_next;

   // access qualification
   assign wsig        = signed'(i_req.wdata);
   assign sig_in_span = (wsig >= signed'(`HP_FULL_NEG)) &&
                        (wsig <= signed'(`HP_FULL_POS)); // RULE1
   assign acc_ok      = i_req.valid && i_req.from_comm; // RULE2
   assign wr_ok       = acc_ok && i_req.write;
   assign wr_main     = wr_ok && (i_req.code == `HP_CODE_MAIN) &&
                        sig_in_span; // RULE5
   assign wr_tlim     = wr_ok && (i_req.code == `HP_CODE_TLIM) &&
                        sig_in_span; // RULE8
   assign wr_field    = wr_ok && (i_req.code == `HP_CODE_FIELD) &&
                        (i_req.wdata <= `HP_FULL_POS); // RULE15
   assign pd_field    = i_pd_valid && i_pd_map_field &&
                        (i_pd_word <= `HP_FULL_POS); // RULE16

   // field setpoint candidate, parameter write beats process word
   assign fld_src    = wr_field ? i_req.wdata : i_pd_word;
   assign min_eff    = (i_min_field > `HP_FULL_POS) ? `HP_FULL_POS
                                                    : i_min_field;
   assign fld_floor  = (fld_src < min_eff) ? min_eff : fld_src; // RULE13
   assign fld_next   = (i_field_weak && (fld_floor > keep_floor)) ?
                       keep_floor : fld_floor; // RULE14
   assign keep_floor = (field_reg < min_eff) ? min_eff : field_reg; // RULE13

   // loop input sum, saturated
   assign loop_sum = {i_main_ramped[15], i_main_ramped} +
                     {i_extra_ramped[15], i_extra_ramped};
   always_comb begin
      if (loop_sum > signed'(`HP_SUM_POS)) begin
         loop_sat = 16'h7fff; // RULE6
      end else if (loop_sum < signed'(`HP_SUM_NEG)) begin
         loop_sat = 16'h8001; // RULE6
      end else begin
         loop_sat = loop_sum[15:0]; // RULE6
      end
   end

   // phase view, blanked before zero mark on incremental feedback
   assign phase_view = (i_enc_incremental && !zero_seen_reg) ?
                       16'h0000 : i_phase_count; // RULE12

   // answer decode, raw controller values without scaling
   always_comb begin
      rsp_next       = '0;
      rsp_next.ack   = i_req.valid;
      rsp_next.err   = i_req.valid && !i_req.from_comm; // RULE2
      if (acc_ok) begin
         case (i_req.code)
            `HP_CODE_MAIN: begin
               rsp_next.rdata = main_reg; // RULE3
               rsp_next.err   = i_req.write && !sig_in_span;
            end
            `HP_CODE_LOOP: begin
               rsp_next.rdata = loop_sat; // RULE6
               rsp_next.err   = i_req.write;
            end
            `HP_CODE_MEAS: begin
               rsp_next.rdata = i_speed_meas; // RULE7
               rsp_next.err   = i_req.write;
            end
            `HP_CODE_TLIM: begin
               rsp_next.rdata = tlim_reg; // RULE8
               rsp_next.err   = i_req.write && !sig_in_span;
            end
            `HP_CODE_TDEM: begin
               rsp_next.rdata = i_torque_demand; // RULE9
               rsp_next.err   = i_req.write;
            end
            `HP_CODE_PHASE: begin
               rsp_next.rdata = phase_view; // RULE10 RULE11
               rsp_next.err   = i_req.write;
            end
            `HP_CODE_FIELD: begin
               rsp_next.rdata = field_reg; // RULE15
               rsp_next.err   = i_req.write && !wr_field;
            end
            `HP_CODE_EXTRA: begin
               rsp_next.rdata = i_extra_setpoint; // RULE17
               rsp_next.err   = i_req.write;
            end
            default: begin
               rsp_next.err = 1'b1;
            end
         endcase
      end
   end

   // answer register
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end

   // main speed setpoint, raw 16-bit two's complement
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         main_reg <= `HP_MAIN_RESET;
      end else if (wr_main) begin
         main_reg <= wsig; // RULE4
      end
   end

   // torque limit
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         tlim_reg <= `HP_TLIM_RESET;
      end else if (wr_tlim) begin
         tlim_reg <= wsig; // RULE18
      end
   end

   // field current setpoint, floor tracked every cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         field_reg <= `HP_FIELD_RESET;
      end else if (wr_field || pd_field) begin
         field_reg <= fld_next; // RULE16
      end else begin
         field_reg <= keep_floor; // RULE13
      end
   end

   // zero mark synchroniser
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         zm_meta_reg <= 1'b0;
         zm_sync_reg <= 1'b0;
      end else begin
         zm_meta_reg <= i_zero_mark;
         zm_sync_reg <= zm_meta_reg;
      end
   end

   // zero mark seen, sticky until reset
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         zero_seen_reg <= 1'b0;
      end else if (zm_sync_reg) begin
         zero_seen_reg <= 1'b1; // RULE12
      end
   end

   // outputs
   assign o_rsp            = rsp_reg;
   assign o_main_setpoint  = main_reg;
   assign o_torque_limit   = tlim_reg;
   assign o_field_setpoint = field_reg;

   // checks
   a_main_span_hold: assert property (@(posedge i_clk_sys) // RULE5
      disable iff (i_reset)
      (main_reg >= signed'(`HP_FULL_NEG)) &&
      (main_reg <= signed'(`HP_FULL_POS)))
      else $error("main setpoint out of span");

   a_main_write_direct: assert property (@(posedge i_clk_sys) // RULE3
      disable iff (i_reset)
      wr_main |=> (o_main_setpoint == $past(wsig)) ##1
      (o_main_setpoint == $past(wsig, 2)) || $past(wr_main))
      else $error("main setpoint not stored as written");

   a_tlim_span_hold: assert property (@(posedge i_clk_sys) // RULE8
      disable iff (i_reset)
      (tlim_reg >= signed'(`HP_FULL_NEG)) &&
      (tlim_reg <= signed'(`HP_FULL_POS)))
      else $error("torque limit out of span");

   a_keypad_access_refused: assert property (@(posedge i_clk_sys) // RULE2
      disable iff (i_reset)
      (i_req.valid && !i_req.from_comm) |=> o_rsp.ack && o_rsp.err &&
      (o_rsp.rdata == 16'h0000))
      else $error("keypad access was not refused");

   a_ack_one_cycle: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      i_req.valid |=> o_rsp.ack ##1 (o_rsp.ack == $past(i_req.valid)))
      else $error("answer not one cycle after request");

   a_loop_sum_span: assert property (@(posedge i_clk_sys) // RULE6
      disable iff (i_reset)
      (acc_ok && (i_req.code == `HP_CODE_LOOP)) |=>
      (signed'(o_rsp.rdata) >= signed'(16'h8001)) &&
      (o_rsp.rdata[15] == $past(loop_sum[16])))
      else $error("loop input sum wrong or out of span");

   a_phase_zero_blank: assert property (@(posedge i_clk_sys) // RULE12
      disable iff (i_reset)
      (acc_ok && (i_req.code == `HP_CODE_PHASE) && i_enc_incremental &&
       !zero_seen_reg) |=> (o_rsp.rdata == 16'h0000))
      else $error("phase shown before zero mark");

   a_field_floor_held: assert property (@(posedge i_clk_sys) // RULE13
      disable iff (i_reset)
      !$past(i_reset) |-> (o_field_setpoint >= $past(min_eff)))
      else $error("field setpoint below minimum");

   a_field_weak_kept: assert property (@(posedge i_clk_sys) // RULE14
      disable iff (i_reset)
      (i_field_weak && (wr_field || pd_field) && (min_eff <= field_reg))
      |=> (field_reg <= $past(field_reg)))
      else $error("field weakening left by larger setpoint");

   a_field_span_hold: assert property (@(posedge i_clk_sys) // RULE15
      disable iff (i_reset)
      field_reg <= `HP_FULL_POS)
      else $error("field setpoint above rated");

   a_idle_answer_zero: assert property (@(posedge i_clk_sys)
      disable iff (i_reset)
      !i_req.valid |=> (o_rsp == '0))
      else $error("answer shown without a request");

   a_ro_write_refused: assert property (@(posedge i_clk_sys) // RULE7
      disable iff (i_reset)
      (wr_ok && ((i_req.code == `HP_CODE_LOOP) ||
                 (i_req.code == `HP_CODE_MEAS) ||
                 (i_req.code == `HP_CODE_TDEM) ||
                 (i_req.code == `HP_CODE_PHASE) ||
                 (i_req.code == `HP_CODE_EXTRA))) |=> o_rsp.err)
      else $error("write to read-only word accepted");

   a_meas_read_direct: assert property (@(posedge i_clk_sys) // RULE7
      disable iff (i_reset)
      (acc_ok && (i_req.code == `HP_CODE_MEAS)) |=>
      (o_rsp.rdata == $past(i_speed_meas)))
      else $error("measured speed not returned unchanged");

   a_tdem_read_direct: assert property (@(posedge i_clk_sys) // RULE9
      disable iff (i_reset)
      (acc_ok && (i_req.code == `HP_CODE_TDEM)) |=>
      (o_rsp.rdata == $past(i_torque_demand)))
      else $error("torque demand not returned unchanged");

   a_extra_read_direct: assert property (@(posedge i_clk_sys) // RULE17
      disable iff (i_reset)
      (acc_ok && (i_req.code == `HP_CODE_EXTRA)) |=>
      (o_rsp.rdata == $past(i_extra_setpoint)))
      else $error("extra setpoint not returned unchanged");

   a_phase_read_direct: assert property (@(posedge i_clk_sys) // RULE11
      disable iff (i_reset)
      (acc_ok && (i_req.code == `HP_CODE_PHASE) &&
       (!i_enc_incremental || zero_seen_reg)) |=>
      (o_rsp.rdata == $past(i_phase_count)))
      else $error("rotor phase not returned unchanged");

   a_zero_mark_set: assert property (@(posedge i_clk_sys) // RULE12
      disable iff (i_reset)
      zm_sync_reg |=> zero_seen_reg)
      else $error("zero mark not recorded");

   a_tlim_write_direct: assert property (@(posedge i_clk_sys) // RULE8
      disable iff (i_reset)
      wr_tlim |=> (o_torque_limit == $past(wsig)))
      else $error("torque limit not stored as written");

   a_pd_field_load: assert property (@(posedge i_clk_sys) // RULE16
      disable iff (i_reset)
      (pd_field && !wr_field && !i_field_weak &&
       (i_pd_word >= min_eff)) |=>
      (o_field_setpoint == $past(i_pd_word)))
      else $error("process word not loaded into field setpoint");

endmodule : hp_value_bank

// ### hp_host_model.sv
// host model issuing parameter accesses to the value bank
`timescale 1ns/1ns
module hp_host_model
   import hp_pkg::*;
(
   // clock
   input  wire logic i_clk_sys,
   // request to the bank
   output hp_req_type o_req
);
   // one access per call, back to back when called in a row
   task automatic access(input logic w, c, input logic [10:0] a,
                         input logic [15:0] d);
      @(posedge i_clk_sys);
      #1;
      o_req = '{1'b1, w, c, a, d};
   endtask : access

   // release; stale fields inverted so they never look valid
   task automatic idle();
      @(posedge i_clk_sys);
      #1;
      o_req = '{1'b0, 1'b0, 1'b0, ~o_req.code, ~o_req.wdata};
   endtask : idle

   // quiet at time zero
   initial o_req = '0;
endmodule : hp_host_model

// ### hp_value_bank_tb_top.sv
// self-checking bench for the high-precision value bank
`timescale 1ns/1ns
`include "hp_defines.svh"
module hp_value_bank_tb_top import hp_pkg::*;;
   logic               clk, rst, inc, zm, fw, pv, pm;
   logic signed [15:0] mr, xr, sm, td, xs, o_ms, o_tl;
   logic [15:0]        ph, mf, pw, rv, o_fs;
   hp_req_type         req;
   hp_rsp_type         rsp, nt;
   hp_rsp_type         q[$];
   int                 bad_count, comparisons;

   hp_host_model host (.i_clk_sys(clk), .o_req(req));
   hp_value_bank DUT (.i_clk_sys(clk), .i_reset(rst), .i_req(req),
      .o_rsp(rsp), .i_main_ramped(mr), .i_extra_ramped(xr),
      .i_speed_meas(sm), .i_torque_demand(td), .i_extra_setpoint(xs),
      .i_phase_count(ph), .i_enc_incremental(inc), .i_zero_mark(zm),
      .i_field_weak(fw), .i_min_field(mf), .i_pd_valid(pv),
      .i_pd_map_field(pm), .i_pd_word(pw), .o_main_setpoint(o_ms),
      .o_torque_limit(o_tl), .o_field_setpoint(o_fs));

   // clock, 10 ns period
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string n, input logic [16:0] s, e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // note the expected answer, then issue the access
   task automatic acc(input logic w, c, input logic [10:0] a,
                      input logic [15:0] d, input logic er,
                      input logic [15:0] rd);
      q.push_back(hp_rsp_type'{1'b1, er, rd});
      host.access(w, c, a, d);
   endtask : acc

   task automatic nx();
      @(posedge clk);
      #1;
   endtask : nx

   // end a test once every answer has arrived, bounded wait
   task automatic fin(input string n);
      int k;
      host.idle();
      for (k = 0; k < 20 && q.size() != 0; k++) @(posedge clk);
      if (q.size() != 0) begin
         chk("answer wait", 17'h1, 17'h0);
         close_out();
      end else begin
         $display("test %s done", n);
         nx();
      end
   endtask : fin

   // answer stands one cycle; compare with oldest note
   always @(negedge clk) begin
      if (rsp.ack === 1'b1) begin
         nt = (q.size() != 0) ? q.pop_front() : '0;
         chk("noted", {16'h0, nt.ack}, 17'h1);
         chk("answer", {rsp.err, rsp.rdata}, {nt.err, nt.rdata});
      end
   end

   // main sequence
   initial begin
      {mr, xr, sm, td, xs, ph, pw} = '0;
      {inc, zm, fw, pv, pm} = '0;
      mf = 16'h1000;
      rst = 1;
      rv = 16'($urandom(32'hf128caee));
      repeat (3) @(posedge clk);
      #1;
      rst = 0;
      acc(0, 1, `HP_CODE_MAIN, 0, 0, 16'h0000);
      acc(0, 1, `HP_CODE_TLIM, 0, 0, 16'h4000);
      acc(0, 1, `HP_CODE_FIELD, 0, 0, 16'h4000);
      fin("reset");
      rv = 16'($urandom_range(32768)) - 16'h4000;
      acc(1, 1, `HP_CODE_MAIN, 16'h4000, 0, 16'h0000);
      acc(1, 1, `HP_CODE_MAIN, 16'hc000, 0, 16'h4000);
      acc(1, 1, `HP_CODE_MAIN, rv, 0, 16'hc000);
      acc(1, 0, `HP_CODE_MAIN, 16'h0001, 1, 16'h0000);
      acc(0, 1, `HP_CODE_MAIN, 0, 0, rv);
      fin("main");
      chk("main out", {1'b0, o_ms}, {1'b0, rv});
      mr = 16'h7000;
      xr = 16'h7000;
      sm = 16'($urandom);
      td = 16'hc000;
      xs = 16'h4000;
      acc(0, 1, `HP_CODE_LOOP, 0, 0, 16'h7fff);
      acc(1, 1, `HP_CODE_LOOP, 16'h0005, 1, 16'h7fff);
      acc(0, 1, `HP_CODE_MEAS, 0, 0, sm);
      acc(0, 1, `HP_CODE_TDEM, 0, 0, 16'hc000);
      acc(0, 1, `HP_CODE_EXTRA, 0, 0, 16'h4000);
      acc(0, 1, 11'h17f, 0, 1, 16'h0000);
      fin("read only");
      mr = 16'h9000;
      xr = 16'h9000;
      acc(0, 1, `HP_CODE_LOOP, 0, 0, 16'h8001);
      acc(1, 1, `HP_CODE_TLIM, 16'hc000, 0, 16'h4000);
      acc(0, 1, `HP_CODE_TLIM, 0, 0, 16'hc000);
      acc(1, 1, `HP_CODE_TLIM, 16'h4001, 1, 16'hc000);
      fin("torque");
      chk("torque out", {1'b0, o_tl}, 17'h0c000);
      ph = 16'hffff;
      acc(0, 1, `HP_CODE_PHASE, 0, 0, 16'hffff);
      fin("phase resolver");
      inc = 1;
      acc(0, 1, `HP_CODE_PHASE, 0, 0, 16'h0000);
      fin("phase no mark");
      zm = 1;
      nx();
      zm = 0;
      repeat (4) nx();
      ph = 16'h4000;
      acc(0, 1, `HP_CODE_PHASE, 0, 0, 16'h4000);
      fin("phase marked");
      acc(1, 1, `HP_CODE_FIELD, 16'h0100, 0, 16'h4000);
      acc(0, 1, `HP_CODE_FIELD, 0, 0, 16'h1000);
      acc(1, 1, `HP_CODE_FIELD, 16'h4001, 1, 16'h1000);
      fin("field floor");
      fw = 1;
      acc(1, 1, `HP_CODE_FIELD, 16'h3000, 0, 16'h1000);
      acc(0, 1, `HP_CODE_FIELD, 0, 0, 16'h1000);
      fin("field weak");
      fw = 0;
      {pv, pm, pw} = {2'b11, 16'h2000};
      nx();
      pv = 0;
      acc(0, 1, `HP_CODE_FIELD, 0, 0, 16'h2000);
      fin("process word");
      chk("field out", {1'b0, o_fs}, 17'h02000);
      close_out();
   end
endmodule : hp_value_bank_tb_top
